// File: src/ehsp_pkg.sv
package ehsp_pkg;

    // ----------------------------------------------------------------
    // Frame widths and fill values
    // ----------------------------------------------------------------
    localparam logic [3:0] BITS_4W   = 4'h8;
    localparam logic [3:0] BITS_3W   = 4'h9;
    localparam logic [7:0] HW_4W     = 8'h08;
    localparam logic [7:0] HW_3W     = 8'h09;
    localparam logic [7:0] HW_3W_RD  = 8'h0A;
    localparam logic [7:0] RD_FILL   = 8'h00;
    localparam int         BUF_W     = 9;
    localparam int         BUF_DEPTH = 2;

    // ----------------------------------------------------------------
    // Pin synchroniser slots and their reset levels
    // ----------------------------------------------------------------
    localparam int         SYN_SCLK  = 0;
    localparam int         SYN_CS    = 1;
    localparam int         SYN_DC    = 2;
    localparam int         SYN_SDA   = 3;
    localparam int         SYN_RSTN  = 4;
    localparam int         SYN_STRAP = 5;
    localparam int         SYN_N     = 6;
    localparam logic [5:0] SYN_RST   = 6'h02;

    // ----------------------------------------------------------------
    // Link timing, read-mode figures serve both directions
    // ----------------------------------------------------------------
    localparam int         CLK_NS        = 8;
    localparam int         T_SCL_HALF_NS = 180;
    localparam int         T_CSSU_NS     = 100;
    localparam int         T_CSHLD_NS    = 65;
    localparam int         T_CSHIGH_NS   = 250;
    localparam logic [5:0] SCL_HALF_CYC  = 6'((T_SCL_HALF_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [5:0] CSSU_CYC      = 6'((T_CSSU_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [5:0] CSHLD_CYC     = 6'((T_CSHLD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [5:0] CSHIGH_CYC    = 6'((T_CSHIGH_NS + CLK_NS - 1) / CLK_NS);

    // ----------------------------------------------------------------
    // State machines
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {DV_RX, DV_READ} ehsp_dev_state_t;
    typedef enum logic [2:0] {HS_IDLE, HS_SETUP, HS_LOW, HS_HIGH, HS_HOLD, HS_GAP}
        ehsp_host_state_t;

endpackage

// File: src/ehsp_if.sv
`timescale 1ns/1ps
interface ehsp_if;
    logic sclk;
    logic cs_n;
    logic dc;
    logic sda_h;
    logic sda_h_oe;
    logic sda_d;
    logic sda_d_oe;
    logic sda;
    logic busy;
    logic reset_n_pin;
    logic interface_mode_strap;

    // Wire level of the shared data line, pulled high when idle
    assign sda = sda_h_oe ? sda_h : (sda_d_oe ? sda_d : 1'b1);

    modport device (input sclk, cs_n, dc, sda, reset_n_pin, interface_mode_strap,
                    output sda_d, sda_d_oe, busy);
    modport host   (output sclk, cs_n, dc, sda_h, sda_h_oe, reset_n_pin,
                    output interface_mode_strap, input sda, busy);
endinterface

// File: src/ehsp_buf2.sv
`timescale 1ns/1ps
module ehsp_buf2 #(
    parameter int W     = 9,
    parameter int DEPTH = 2
) (
    input  logic         clk_sys,
    input  logic         rst,
    input  logic         clr,
    input  logic         in_valid,
    output logic         in_ready,
    input  logic [W-1:0] in_data,
    output logic         out_valid,
    input  logic         out_ready,
    output logic [W-1:0] out_data
);
    logic [DEPTH-1:0]          vld_reg;
    logic [DEPTH-1:0][W-1:0]   mem_reg;
    logic [DEPTH:0]            vx;
    logic [DEPTH:0][W-1:0]     mx;
    logic [DEPTH-1:0]          sv;
    logic [DEPTH:0]            svp;
    logic [DEPTH-1:0][W-1:0]   sm;
    logic [DEPTH-1:0]          ld;
    logic                      pop;
    logic                      push;

    // Head is always entry 0, so the outputs are plain flops
    assign pop       = vld_reg[0] & out_ready;
    assign push      = in_valid & in_ready;
    assign in_ready  = ~vld_reg[DEPTH-1];
    assign out_valid = vld_reg[0];
    assign out_data  = mem_reg[0];
    assign vx        = {1'b0, vld_reg};
    assign mx        = {{W{1'b0}}, mem_reg};
    assign svp       = {sv, 1'b1};

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++)
        begin : g_ent
            // Shift down on pop, then fill the first empty slot
            assign sv[i] = pop ? vx[i+1] : vx[i];
            assign sm[i] = pop ? mx[i+1] : mx[i];
            assign ld[i] = push & ~sv[i] & svp[i];

            always_ff @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    vld_reg[i] <= 1'b0;
                    mem_reg[i] <= '0;
                end
                else
                begin
                    vld_reg[i] <= ~clr & (sv[i] | ld[i]);
                    mem_reg[i] <= ld[i] ? in_data : sm[i];
                end
            end
        end
    endgenerate
endmodule

// File: src/ehsp_device.sv
`timescale 1ns/1ps
// Operation
// R01: Act only while select is low
// R02: Four-wire: pin high data, low command
// R03: Held in reset while reset pin low
// R04: Busy high during waveform or sensor traffic
// R05: Host sends nothing while busy high
// R06: Strap low eight bits, high nine bits
// R07: Three-wire: flag from stream, pin ignored
// R08: Shift in on rising edges, MSB first
// R09: Host holds data/command pin per byte
// R10: Route finished byte as data or command
// R11: Host read: select, then register byte
// R12: Host raises data/command after last fall
// R13: Read data changes on falling edges, MSB first
// R14: Several read bytes; host ends with select
// R15: Three-wire frame: flag then bits 7..0
// R16: Flag one data, flag zero command
// R17: Three-wire read: zero flag, byte, one flag
// R18: Select high drops partial byte, counter cleared
module ehsp_device
    import ehsp_pkg::*;
(
    input  logic        clk_sys,
    input  logic        rst,
    ehsp_if.device      bus,
    output logic        rx_valid,
    input  logic        rx_ready,
    output logic [7:0]  rx_data,
    output logic        rx_is_data,
    input  logic [7:0]  tx_data,
    input  logic        tx_valid,
    output logic        tx_ready,
    input  logic        busy_req,
    output logic        mode_3wire,
    output logic        in_reset
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [SYN_N-1:0] pin_raw;
    logic [SYN_N-1:0] meta_reg;
    logic [SYN_N-1:0] sync_reg;

    assign pin_raw = {bus.interface_mode_strap, bus.reset_n_pin, bus.sda,
                      bus.dc, bus.cs_n, bus.sclk};

    genvar g;
    generate
        for (g = 0; g < SYN_N; g++)
        begin : g_sync
            // Two stages per pin; only the second is read
            always_ff @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    meta_reg[g] <= SYN_RST[g];
                    sync_reg[g] <= SYN_RST[g];
                end
                else
                begin
                    meta_reg[g] <= pin_raw[g];
                    sync_reg[g] <= meta_reg[g];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    ehsp_dev_state_t state_reg;
    logic [3:0]      bit_cnt_reg;
    logic [8:0]      sr_reg;
    logic            last_cmd_reg;
    logic            mode3_reg;
    logic            push_reg;
    logic [8:0]      push_data_reg;
    logic [7:0]      tx_sh_reg;
    logic [2:0]      rd_cnt_reg;
    logic            sda_d_reg;
    logic            sda_oe_reg;
    logic            tx_ready_reg;
    logic            busy_reg;
    logic            sclk_d_reg;
    logic            pin_rst_reg;
    logic            buf_in_ready;
    logic [8:0]      buf_out;

    logic            sel;
    logic            pin_rst;
    logic            sclk_rise;
    logic            sclk_fall;
    logic            frame_clr;
    logic [3:0]      bits_need;
    logic [3:0]      cnt_inc;
    logic [8:0]      sr_shift;
    logic            byte_done;
    logic            flag_now;
    logic            rd_gate;
    logic            rd_enter;
    logic            rd_load;
    logic [7:0]      tx_byte;

    // ----------------------------------------------------------------
    // Edge and frame decode
    // ----------------------------------------------------------------
    // R01: gate on select
    assign sel       = ~sync_reg[SYN_CS];
    assign sclk_rise = sel & sync_reg[SYN_SCLK] & ~sclk_d_reg;
    assign sclk_fall = sel & ~sync_reg[SYN_SCLK] & sclk_d_reg;
    // R03: pin reset clears logic
    assign pin_rst   = ~sync_reg[SYN_RSTN];
    // R18: deselect ends frame
    assign frame_clr = pin_rst | ~sel;

    // R06: eight or nine bits
    assign bits_need = mode3_reg ? BITS_3W : BITS_4W;
    assign cnt_inc   = 4'(bit_cnt_reg + 4'h1);
    // R08: MSB first shift
    assign sr_shift  = {sr_reg[7:0], sync_reg[SYN_SDA]};
    // R15: flag then byte
    assign byte_done = sclk_rise & (state_reg == DV_RX) & (cnt_inc == bits_need);
    // R07: three-wire flag source
    // R02: four-wire pin level
    assign flag_now  = mode3_reg ? sr_shift[8] : sync_reg[SYN_DC];

    // R17: wait for the one flag in three-wire
    assign rd_gate  = mode3_reg ? ((bit_cnt_reg == 4'h1) & sr_reg[0]) : (bit_cnt_reg == 4'h0);
    assign rd_enter = sclk_fall & (state_reg == DV_RX) & last_cmd_reg & tx_valid & rd_gate;
    // R14: reload each eight bits until deselect
    assign rd_load  = rd_enter | (sclk_fall & (state_reg == DV_READ) & (rd_cnt_reg == 3'h0));
    assign tx_byte  = tx_valid ? tx_data : RD_FILL;

    // ----------------------------------------------------------------
    // Receive path
    // ----------------------------------------------------------------
    // Bit counter, shift register and mode
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sclk_d_reg  <= 1'b0;
            bit_cnt_reg <= 4'h0;
            sr_reg      <= 9'h000;
            mode3_reg   <= 1'b0;
            pin_rst_reg <= 1'b1;
        end
        else
        begin
            sclk_d_reg  <= sync_reg[SYN_SCLK];
            pin_rst_reg <= pin_rst;
            // R06: mode latched only between frames
            if (~sel)
                mode3_reg <= sync_reg[SYN_STRAP];
            // R18: partial byte discarded
            if (frame_clr)
                bit_cnt_reg <= 4'h0;
            else if (sclk_rise & (state_reg == DV_RX))
                bit_cnt_reg <= byte_done ? 4'h0 : cnt_inc;
            if (sclk_rise)
                sr_reg <= sr_shift;
        end
    end

    // Finished byte hand-off to the buffer
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            push_reg      <= 1'b0;
            push_data_reg <= 9'h000;
            last_cmd_reg  <= 1'b0;
        end
        else
        begin
            // R10: route by flag
            // R16: flag one is data
            push_reg <= byte_done & ~pin_rst;
            if (byte_done)
                push_data_reg <= {flag_now, sr_shift[7:0]};
            if (frame_clr)
                last_cmd_reg <= 1'b0;
            else if (byte_done)
                last_cmd_reg <= ~flag_now;
        end
    end

    // Busy also rises when the buffer fills, so the host holds off
    ehsp_buf2 #(
        .W     (BUF_W),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .clr       (pin_rst),
        .in_valid  (push_reg),
        .in_ready  (buf_in_ready),
        .in_data   (push_data_reg),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (buf_out)
    );

    assign rx_is_data = buf_out[8];
    assign rx_data    = buf_out[7:0];

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Read state, bit count and output driver
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_reg    <= DV_RX;
            rd_cnt_reg   <= 3'h0;
            tx_sh_reg    <= 8'h00;
            sda_d_reg    <= 1'b1;
            sda_oe_reg   <= 1'b0;
            tx_ready_reg <= 1'b0;
        end
        else
        begin
            tx_ready_reg <= rd_load & tx_valid & ~frame_clr;
            if (frame_clr)
            begin
                state_reg  <= DV_RX;
                rd_cnt_reg <= 3'h0;
                sda_oe_reg <= 1'b0;
            end
            else
            begin
                if (rd_enter)
                    state_reg <= DV_READ;
                if (sclk_rise & (state_reg == DV_READ))
                    rd_cnt_reg <= 3'(rd_cnt_reg + 3'h1);
                // R13: change on falling edge
                if (rd_load)
                begin
                    sda_oe_reg <= 1'b1;
                    sda_d_reg  <= tx_byte[7];
                    tx_sh_reg  <= {tx_byte[6:0], 1'b0};
                end
                else if (sclk_fall & (state_reg == DV_READ))
                begin
                    sda_d_reg <= tx_sh_reg[7];
                    tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Busy and status
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            busy_reg <= 1'b0;
        else
            // R04: busy from core or full buffer
            busy_reg <= ~pin_rst & (busy_req | ~buf_in_ready);
    end

    assign bus.sda_d    = sda_d_reg;
    assign bus.sda_d_oe = sda_oe_reg;
    assign bus.busy     = busy_reg;
    assign tx_ready     = tx_ready_reg;
    assign mode_3wire   = mode3_reg;
    assign in_reset     = pin_rst_reg;

endmodule

// File: src/ehsp_host.sv
`timescale 1ns/1ps
module ehsp_host
    import ehsp_pkg::*;
(
    input  logic        clk_sys,
    input  logic        rst,
    ehsp_if.host        bus,
    input  logic        mode_3wire_in,
    input  logic        dev_reset,
    input  logic        cmd_valid,
    output logic        cmd_ready,
    input  logic        cmd_is_data,
    input  logic [7:0]  cmd_data,
    input  logic        cmd_read,
    input  logic [3:0]  cmd_rd_len,
    output logic        rd_valid,
    output logic [7:0]  rd_data,
    output logic        done
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    ehsp_host_state_t state_reg;
    logic [5:0]       tmr_reg;
    logic [7:0]       bit_reg;
    logic [7:0]       wbits_reg;
    logic [7:0]       total_reg;
    logic [9:0]       sh_reg;
    logic [7:0]       rd_sh_reg;
    logic             read_reg;
    logic             sclk_reg;
    logic             cs_n_reg;
    logic             dc_reg;
    logic             sda_reg;
    logic             sda_oe_reg;
    logic             rd_valid_reg;
    logic [7:0]       rd_data_reg;
    logic             done_reg;
    logic             ready_reg;
    logic             rstn_reg;
    logic             strap_reg;
    logic [1:0]       busy_meta_reg;
    logic [1:0]       sda_meta_reg;

    logic             busy_s;
    logic             sda_s;
    logic             accept;
    logic             tmr_zero;
    logic [7:0]       bit_inc;
    logic [7:0]       rb;
    logic [7:0]       rd_next;
    logic [7:0]       wbits_new;
    logic [9:0]       sh_new;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    assign busy_s    = busy_meta_reg[1];
    assign sda_s     = sda_meta_reg[1];
    assign accept    = cmd_valid & ready_reg;
    assign tmr_zero  = (tmr_reg == 6'h00);
    assign bit_inc   = 8'(bit_reg + 8'h01);
    assign rb        = 8'(bit_reg - wbits_reg);
    assign rd_next   = {rd_sh_reg[6:0], sda_s};
    // Read commands always go out as commands
    assign wbits_new = strap_reg ? (cmd_read ? HW_3W_RD : HW_3W) : HW_4W;
    assign sh_new    = strap_reg ? {cmd_is_data & ~cmd_read, cmd_data, 1'b1}
                                 : {cmd_data, 2'b00};

    // Busy and data pins, two stages each
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            busy_meta_reg <= 2'h3;
            sda_meta_reg  <= 2'h3;
        end
        else
        begin
            busy_meta_reg <= {busy_meta_reg[0], bus.busy};
            sda_meta_reg  <= {sda_meta_reg[0], bus.sda};
        end
    end

    // ----------------------------------------------------------------
    // Transfer sequencer, clock divided down from clk_sys
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_reg    <= HS_IDLE;
            tmr_reg      <= 6'h00;
            bit_reg      <= 8'h00;
            wbits_reg    <= 8'h00;
            total_reg    <= 8'h00;
            sh_reg       <= 10'h000;
            rd_sh_reg    <= 8'h00;
            read_reg     <= 1'b0;
            sclk_reg     <= 1'b0;
            cs_n_reg     <= 1'b1;
            dc_reg       <= 1'b0;
            sda_reg      <= 1'b1;
            sda_oe_reg   <= 1'b0;
            rd_valid_reg <= 1'b0;
            rd_data_reg  <= 8'h00;
            done_reg     <= 1'b0;
            ready_reg    <= 1'b0;
            rstn_reg     <= 1'b0;
            strap_reg    <= 1'b0;
        end
        else
        begin
            rd_valid_reg <= 1'b0;
            done_reg     <= 1'b0;
            rstn_reg     <= ~dev_reset;
            // R05: no new transfer while busy
            ready_reg    <= (state_reg == HS_IDLE) & ~busy_s & ~accept & ~dev_reset;
            if (~tmr_zero)
                tmr_reg <= 6'(tmr_reg - 6'h01);
            unique case (state_reg)
                HS_IDLE:
                begin
                    // Strap never moves on the select edge
                    if (accept)
                    begin
                        // R11: select, then register byte
                        // R09: level held for the byte
                        cs_n_reg   <= 1'b0;
                        dc_reg     <= ~strap_reg & cmd_is_data & ~cmd_read;
                        sda_reg    <= sh_new[9];
                        sda_oe_reg <= 1'b1;
                        sh_reg     <= {sh_new[8:0], 1'b0};
                        read_reg   <= cmd_read;
                        bit_reg    <= 8'h00;
                        wbits_reg  <= wbits_new;
                        total_reg  <= 8'(wbits_new + (cmd_read ? {1'b0, cmd_rd_len, 3'h0} : 8'h00));
                        tmr_reg    <= CSSU_CYC;
                        state_reg  <= HS_SETUP;
                    end
                    else
                        strap_reg <= mode_3wire_in;
                end
                HS_SETUP:
                    if (tmr_zero)
                    begin
                        tmr_reg   <= SCL_HALF_CYC;
                        state_reg <= HS_LOW;
                    end
                HS_LOW:
                    if (tmr_zero)
                    begin
                        sclk_reg  <= 1'b1;
                        tmr_reg   <= SCL_HALF_CYC;
                        state_reg <= HS_HIGH;
                        if (bit_reg >= wbits_reg)
                        begin
                            rd_sh_reg    <= rd_next;
                            rd_valid_reg <= (rb[2:0] == 3'h7);
                            if (rb[2:0] == 3'h7)
                                rd_data_reg <= rd_next;
                        end
                    end
                HS_HIGH:
                    if (tmr_zero)
                    begin
                        sclk_reg <= 1'b0;
                        bit_reg  <= bit_inc;
                        if (bit_inc == total_reg)
                        begin
                            tmr_reg   <= CSHLD_CYC;
                            state_reg <= HS_HOLD;
                        end
                        else
                        begin
                            tmr_reg   <= SCL_HALF_CYC;
                            state_reg <= HS_LOW;
                            sda_reg   <= sh_reg[9];
                            sh_reg    <= {sh_reg[8:0], 1'b0};
                            if (bit_inc >= wbits_reg)
                            begin
                                sda_oe_reg <= 1'b0;
                                // R12: raise data/command for read
                                if (~strap_reg)
                                    dc_reg <= 1'b1;
                            end
                        end
                    end
                HS_HOLD:
                    if (tmr_zero)
                    begin
                        // R14: end read by deselect
                        cs_n_reg   <= 1'b1;
                        sda_oe_reg <= 1'b0;
                        done_reg   <= 1'b1;
                        tmr_reg    <= CSHIGH_CYC;
                        state_reg  <= HS_GAP;
                    end
                HS_GAP:
                    if (tmr_zero)
                        state_reg <= HS_IDLE;
            endcase
        end
    end

    assign bus.sclk                 = sclk_reg;
    assign bus.cs_n                 = cs_n_reg;
    assign bus.dc                   = dc_reg;
    assign bus.sda_h                = sda_reg;
    assign bus.sda_h_oe             = sda_oe_reg;
    assign bus.reset_n_pin          = rstn_reg;
    assign bus.interface_mode_strap = strap_reg;
    assign cmd_ready                = ready_reg;
    assign rd_valid                 = rd_valid_reg;
    assign rd_data                  = rd_data_reg;
    assign done                     = done_reg;

endmodule

// File: dv/ehsp_checker.sv
`timescale 1ns/1ps
module ehsp_checker (
    input logic clk_sys,
    input logic rst,
    input logic sclk,
    input logic cs_n,
    input logic dc,
    input logic sda_d,
    input logic sda_d_oe,
    input logic busy,
    input logic reset_n_pin,
    input logic interface_mode_strap
);
    // ----------------------------------------
    // Link behaviour seen on the wires
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // Slack of six cycles covers the pin synchroniser
    a_idle_no_drive: assert property (cs_n [*6] |-> !sda_d_oe)
        else $error("device drives data while deselected");
    a_reset_quiet: assert property (!reset_n_pin [*6] |-> !busy)
        else $error("busy high while device held in reset");
    a_dc_per_byte: assert property (!cs_n && sclk |-> $stable(dc))
        else $error("data/command pin moved while clock high");
    a_three_wire_dc: assert property (!cs_n && interface_mode_strap |-> !dc)
        else $error("data/command pin not low in three-wire mode");
    a_read_start_low: assert property ($rose(sda_d_oe) |-> !sclk && !cs_n)
        else $error("device began driving outside a low clock phase");
    a_read_bit_hold: assert property (sda_d_oe && sclk |-> $stable(sda_d))
        else $error("read bit changed while clock high");
    a_strap_in_frame: assert property (!cs_n && !$past(cs_n) |-> $stable(interface_mode_strap))
        else $error("mode strap moved inside a frame");
    a_hold_off_busy: assert property (busy [*4] |=> !$fell(cs_n))
        else $error("transfer started while busy");
endmodule

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import ehsp_pkg::*;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       mode_3wire_in = 1'b0, dev_reset = 1'b0, cmd_valid = 1'b0, cmd_is_data = 1'b0;
    logic       cmd_read = 1'b0, rx_ready = 1'b1, tx_valid = 1'b0, busy_req = 1'b0;
    logic [7:0] cmd_data = 8'h00, tx_data = 8'h00, rd_data, rx_data;
    logic [3:0] cmd_rd_len = 4'h0;
    logic       cmd_ready, rd_valid, done, rx_valid, rx_is_data, tx_ready, mode_3wire, in_reset;
    logic [8:0] rxq[$], rq[$];
    logic [7:0] txq[$];
    int         err_total = 0, n_checks = 0, cyc = 0;

    ehsp_if bus_if ();
    ehsp_host ehsp_host_inst (.clk_sys, .rst, .bus(bus_if), .mode_3wire_in, .dev_reset,
        .cmd_valid, .cmd_ready, .cmd_is_data, .cmd_data, .cmd_read, .cmd_rd_len, .rd_valid,
        .rd_data, .done);
    ehsp_device ehsp_device_inst (.clk_sys, .rst, .bus(bus_if), .rx_valid, .rx_ready, .rx_data,
        .rx_is_data, .tx_data, .tx_valid, .tx_ready, .busy_req, .mode_3wire, .in_reset);
    ehsp_checker ehsp_checker_inst (.clk_sys, .rst, .sclk(bus_if.sclk), .cs_n(bus_if.cs_n),
        .dc(bus_if.dc), .sda_d(bus_if.sda_d), .sda_d_oe(bus_if.sda_d_oe), .busy(bus_if.busy),
        .reset_n_pin(bus_if.reset_n_pin), .interface_mode_strap(bus_if.interface_mode_strap));

    // ----------------------------------------
    // Clock, capture and core-side read source
    // ----------------------------------------
    always #4 clk_sys = ~clk_sys;

    // Runs about 6k cycles; ceiling leaves wide margin
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            err_total++;
            close_out();
        end
        if (rd_valid === 1'b1) rq.push_back({1'b0, rd_data});
        if (rx_valid === 1'b1 && rx_ready) rxq.push_back({rx_is_data, rx_data});
    end

    // Empty queue drops valid, so a reload sends the fill byte
    always @(negedge clk_sys)
    begin
        if (tx_ready === 1'b1) void'(txq.pop_front());
        tx_valid = txq.size() != 0;
        tx_data = txq.size() != 0 ? txq[0] : 8'h00;
    end

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic take(ref logic [8:0] q[$], input logic [8:0] e);
        chk(q.size() != 0 ? q.pop_front() : ~e, e);
    endtask

    // One command: data flag, byte, read flag, read length
    task automatic send(input logic [13:0] c);
        int k;
        k = 0;
        {cmd_valid, cmd_is_data, cmd_data, cmd_read, cmd_rd_len} = {1'b1, c};
        while (cmd_ready !== 1'b1 && k < 4000)
        begin
            @(negedge clk_sys);
            k++;
        end
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        while (done !== 1'b1 && k < 8000)
        begin
            @(negedge clk_sys);
            k++;
        end
        if (k >= 8000) err_total++;
        repeat (20) @(negedge clk_sys);
    endtask

    task automatic close_out();
        if (err_total == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios in both wire modes, then core busy and pin reset in three-wire only
    // ----------------------------------------
    initial
    begin
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys) rst = 1'b0;
        repeat (10) @(negedge clk_sys);
        for (int m = 0; m < 2; m++)
        begin
            mode_3wire_in = m[0];
            @(negedge clk_sys) rx_ready = 1'b0;
            send({1'b1, 8'hA5, 1'b0, 4'h0});
            send({1'b0, 8'h3C, 1'b0, 4'h0});
            repeat (12) @(negedge clk_sys);
            chk({8'h00, bus_if.busy}, 9'h001);
            chk({8'h00, mode_3wire}, {8'h00, m[0]});
            rx_ready = 1'b1;
            txq = '{8'h5A, 8'hC3};
            send({1'b0, 8'h0A, 1'b1, 4'h3});
            take(rxq, 9'h1A5);
            take(rxq, 9'h03C);
            take(rxq, 9'h00A);
            take(rq, 9'h05A);
            take(rq, 9'h0C3);
            take(rq, 9'h000);
            chk(9'(rxq.size() + rq.size()), 9'h000);
        end
        busy_req = 1'b1;
        repeat (8) @(negedge clk_sys);
        chk({7'h00, bus_if.busy, cmd_ready}, 9'h002);
        dev_reset = 1'b1;
        repeat (12) @(negedge clk_sys);
        chk({7'h00, in_reset, bus_if.busy}, 9'h002);
        {dev_reset, busy_req} = 2'b00;
        repeat (12) @(negedge clk_sys);
        chk({8'h00, in_reset}, 9'h000);
        send({1'b1, 8'h7E, 1'b0, 4'h0});
        take(rxq, 9'h17E);
        close_out();
    end
endmodule
